// ===== rtl/eslp_pkg.sv
package eslp_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int MCLK_MHZ = 25;
    // Bus strobe widths in ns, converted to whole cycles rounding up.
    localparam int STROBE_NS = 120;
    localparam int RECOVER_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * MCLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * MCLK_MHZ + 999) / 1000;
    localparam int CNT_W = 4;
    // Command codes written on the data bus.
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_SET_LOCK = 8'h01;
    localparam logic [7:0] CMD_PROT_SETUP = 8'hc0;
    // Status bit positions.
    localparam int READY_BIT = 7;
    localparam int ERASE_SUSPENDED_BIT = 6;
    localparam int ERASE_ERROR_BIT = 5;
    localparam int PROGRAM_ERROR_BIT = 4;
    localparam int VOLTAGE_ERROR_BIT = 3;
    localparam int LOCK_VIOLATION_BIT = 1;
    // Protection register window in word addresses.
    localparam logic [ADDR_W-1:0] PROT_BASE = 24'h000080;
    localparam logic [ADDR_W-1:0] PROT_LAST = 24'h000088;
    localparam logic [ADDR_W-1:0] PROT_USER_FIRST = 24'h000085;

    typedef enum logic [3:0] {
        ESLP_OP_READ_STATUS,
        ESLP_OP_CLEAR_STATUS,
        ESLP_OP_READ_ARRAY,
        ESLP_OP_READ_ID,
        ESLP_OP_ERASE,
        ESLP_OP_SUSPEND,
        ESLP_OP_RESUME,
        ESLP_OP_PROGRAM,
        ESLP_OP_SET_LOCK,
        ESLP_OP_CLEAR_LOCKS,
        ESLP_OP_PROT_PROGRAM,
        ESLP_OP_READ
    } eslp_op_e;

    typedef struct packed {
        eslp_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eslp_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
    } eslp_cyc_s;
endpackage

// ===== rtl/eslp_bus_cycle.sv
`timescale 1ns/1ps
// Runs one asynchronous write or read cycle on the flash pins.
module eslp_bus_cycle (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire eslp_pkg::eslp_cyc_s cyc,
    output logic busy,
    output logic done,
    output logic [eslp_pkg::DATA_W-1:0] rdata,
    output logic [eslp_pkg::ADDR_W-1:0] flashAddr,
    output logic [eslp_pkg::DATA_W-1:0] flashDqOut,
    output logic flashDqOe_n,
    input wire logic [eslp_pkg::DATA_W-1:0] flashDqIn,
    output logic flashCe_n,
    output logic flashWe_n,
    output logic flashOe_n
);
    typedef enum logic [1:0] {ESLP_BC_IDLE, ESLP_BC_STROBE, ESLP_BC_RECOVER} eslp_bc_e;
    eslp_bc_e state, next_state;
    logic [eslp_pkg::CNT_W-1:0] count, next_count;
    logic isWrite, next_isWrite;
    logic [eslp_pkg::DATA_W-1:0] next_rdata;
    logic [eslp_pkg::ADDR_W-1:0] next_flashAddr;
    logic [eslp_pkg::DATA_W-1:0] next_flashDqOut;

    // Strobe is held for the access time, then released for recovery.
    always_comb begin
        next_state = state;
        next_count = count;
        next_isWrite = isWrite;
        next_rdata = rdata;
        next_flashAddr = flashAddr;
        next_flashDqOut = flashDqOut;
        done = 1'b0;
        case (state)
            ESLP_BC_IDLE: begin
                if (start) begin
                    next_state = ESLP_BC_STROBE;
                    next_count = eslp_pkg::CNT_W'(eslp_pkg::STROBE_CYC - 1);
                    next_isWrite = cyc.write;
                    next_flashAddr = cyc.addr;
                    next_flashDqOut = cyc.wdata;
                end
            end
            ESLP_BC_STROBE: begin
                if (count == '0) begin
                    next_state = ESLP_BC_RECOVER;
                    next_count = eslp_pkg::CNT_W'(eslp_pkg::RECOVER_CYC - 1);
                    if (!isWrite) begin
                        next_rdata = flashDqIn;
                    end
                end else begin
                    next_count = count - 1'b1;
                end
            end
            ESLP_BC_RECOVER: begin
                if (count == '0) begin
                    next_state = ESLP_BC_IDLE;
                    done = 1'b1;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            default: next_state = ESLP_BC_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ESLP_BC_IDLE;
            count <= '0;
            isWrite <= 1'b0;
            rdata <= '0;
            flashAddr <= '0;
            flashDqOut <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            isWrite <= next_isWrite;
            rdata <= next_rdata;
            flashAddr <= next_flashAddr;
            flashDqOut <= next_flashDqOut;
        end
    end

    // Data is driven for the whole write cycle, strobe and recovery, so the device can drive reads.
    assign busy = (state != ESLP_BC_IDLE);
    assign flashCe_n = (state != ESLP_BC_STROBE);
    assign flashWe_n = !(state == ESLP_BC_STROBE && isWrite);
    assign flashOe_n = !(state == ESLP_BC_STROBE && !isWrite);
    assign flashDqOe_n = !(state != ESLP_BC_IDLE && isWrite);
endmodule

// ===== rtl/eslp_host_ctrl.sv
`timescale 1ns/1ps
// Host-side sequencer for erase suspend, lock bits and protection programming.
module eslp_host_ctrl (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire eslp_pkg::eslp_req_s req,
    input wire logic reqValid,
    output logic reqReady,
    output logic respValid,
    output logic [eslp_pkg::DATA_W-1:0] respData,
    output logic refused,
    output logic nestLevel2,
    output logic eraseSuspendedSeen,
    output logic [eslp_pkg::ADDR_W-1:0] flashAddr,
    output logic [eslp_pkg::DATA_W-1:0] flashDqOut,
    output logic flashDqOe_n,
    input wire logic [eslp_pkg::DATA_W-1:0] flashDqIn,
    output logic flashCe_n,
    output logic flashWe_n,
    output logic flashOe_n,
    input wire logic statusOutputPin,
    input wire logic programEnableOk
);
    typedef enum logic [2:0] {
        ESLP_IDLE, ESLP_CYC1, ESLP_CYC2, ESLP_WAIT, ESLP_DONE
    } eslp_state_e;
    eslp_state_e state, next_state;
    eslp_pkg::eslp_req_s cur, next_cur;
    logic [eslp_pkg::DATA_W-1:0] next_respData;
    logic eraseSusp, next_eraseSusp;
    logic progSusp, next_progSusp;
    logic progInSusp, next_progInSusp;
    logic started;
    eslp_pkg::eslp_cyc_s cyc;
    logic cycBusy, cycDone;
    logic [eslp_pkg::DATA_W-1:0] cycRdata;

    // Commands that take two writes put the code in the first one.
    function automatic logic [7:0] first_code(eslp_pkg::eslp_op_e op);
        case (op)
            eslp_pkg::ESLP_OP_READ_ARRAY: first_code = eslp_pkg::CMD_READ_ARRAY;
            eslp_pkg::ESLP_OP_READ_ID: first_code = eslp_pkg::CMD_READ_ID;
            eslp_pkg::ESLP_OP_CLEAR_STATUS: first_code = eslp_pkg::CMD_CLEAR_STATUS;
            eslp_pkg::ESLP_OP_ERASE: first_code = eslp_pkg::CMD_ERASE_SETUP;
            eslp_pkg::ESLP_OP_SUSPEND: first_code = eslp_pkg::CMD_SUSPEND;
            eslp_pkg::ESLP_OP_RESUME: first_code = eslp_pkg::CMD_CONFIRM;
            eslp_pkg::ESLP_OP_PROGRAM: first_code = eslp_pkg::CMD_PROGRAM;
            eslp_pkg::ESLP_OP_SET_LOCK: first_code = eslp_pkg::CMD_LOCK_SETUP;
            eslp_pkg::ESLP_OP_CLEAR_LOCKS: first_code = eslp_pkg::CMD_LOCK_SETUP;
            eslp_pkg::ESLP_OP_PROT_PROGRAM: first_code = eslp_pkg::CMD_PROT_SETUP;
            default: first_code = eslp_pkg::CMD_READ_STATUS;
        endcase
    endfunction

    // Ops with a second write, and ops that start the write state machine.
    function automatic logic two_cycle(eslp_pkg::eslp_op_e op);
        two_cycle = op inside {eslp_pkg::ESLP_OP_ERASE, eslp_pkg::ESLP_OP_PROGRAM,
            eslp_pkg::ESLP_OP_SET_LOCK, eslp_pkg::ESLP_OP_CLEAR_LOCKS,
            eslp_pkg::ESLP_OP_PROT_PROGRAM};
    endfunction

    // Erase, resume and a nested program answer at once so that a suspend can follow.
    function automatic logic waits_ready(eslp_pkg::eslp_op_e op);
        waits_ready = (two_cycle(op) && op != eslp_pkg::ESLP_OP_ERASE && !progInSusp)
            || op == eslp_pkg::ESLP_OP_SUSPEND;
    endfunction

    // A request the device would reject for busy, suspend or lockout state is refused here without bus traffic; lock and range errors go to the device.
    function automatic logic legal(eslp_pkg::eslp_req_s r, logic es, logic ps, logic pis);
        logic busyOrSusp;
        busyOrSusp = es || ps || !statusOutputPin;
        case (r.op)
            eslp_pkg::ESLP_OP_SET_LOCK, eslp_pkg::ESLP_OP_CLEAR_LOCKS:
                legal = !busyOrSusp && programEnableOk;
            eslp_pkg::ESLP_OP_ERASE, eslp_pkg::ESLP_OP_PROT_PROGRAM:
                legal = !busyOrSusp;
            eslp_pkg::ESLP_OP_PROGRAM:
                legal = !ps && statusOutputPin;
            eslp_pkg::ESLP_OP_SUSPEND:
                legal = !statusOutputPin && !(es && !pis) && !ps;
            eslp_pkg::ESLP_OP_RESUME:
                legal = ps || (es && !pis);
            eslp_pkg::ESLP_OP_READ_ID:
                legal = !es && !ps;
            default: legal = 1'b1;
        endcase
    endfunction

    assign started = (state == ESLP_IDLE) && reqValid;
    assign reqReady = (state == ESLP_IDLE);

    // Sequencer: first write, optional second write, then poll ready.
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_respData = respData;
        next_eraseSusp = eraseSusp;
        next_progSusp = progSusp;
        next_progInSusp = progInSusp;
        cyc = '{addr: cur.addr, wdata: {8'h00, first_code(cur.op)}, write: 1'b1};
        respValid = 1'b0;
        refused = 1'b0;
        case (state)
            ESLP_IDLE: begin
                if (reqValid) begin
                    next_cur = req;
                    if (!legal(req, eraseSusp, progSusp, progInSusp)) begin
                        refused = 1'b1;
                        respValid = 1'b1;
                    end else begin
                        next_state = ESLP_CYC1;
                    end
                end
            end
            ESLP_CYC1: begin
                if (cur.op == eslp_pkg::ESLP_OP_READ) begin
                    cyc.write = 1'b0;
                end
                if (cycDone) begin
                    next_respData = cycRdata;
                    if (two_cycle(cur.op)) begin
                        next_state = ESLP_CYC2;
                    end else begin
                        next_state = ESLP_WAIT;
                    end
                end
            end
            ESLP_CYC2: begin
                cyc.wdata = cur.data;
                case (cur.op)
                    eslp_pkg::ESLP_OP_SET_LOCK:
                        cyc.wdata = {8'h00, eslp_pkg::CMD_SET_LOCK};
                    eslp_pkg::ESLP_OP_ERASE, eslp_pkg::ESLP_OP_CLEAR_LOCKS:
                        cyc.wdata = {8'h00, eslp_pkg::CMD_CONFIRM};
                    default: cyc.wdata = cur.data;
                endcase
                if (cycDone) begin
                    next_state = ESLP_WAIT;
                end
            end
            ESLP_WAIT: begin
                // Ready level covers both completion and a reached suspend point.
                if ((statusOutputPin || !waits_ready(cur.op))
                        && !cycBusy) begin
                    next_state = ESLP_DONE;
                    case (cur.op)
                        eslp_pkg::ESLP_OP_SUSPEND: begin
                            if (eraseSusp) begin
                                next_progSusp = 1'b1;
                            end else begin
                                next_eraseSusp = 1'b1;
                            end
                        end
                        eslp_pkg::ESLP_OP_RESUME: begin
                            if (progSusp) begin
                                next_progSusp = 1'b0;
                            end else begin
                                next_eraseSusp = 1'b0;
                            end
                        end
                        eslp_pkg::ESLP_OP_PROGRAM: next_progInSusp = eraseSusp;
                        default: next_state = ESLP_DONE;
                    endcase
                end
            end
            ESLP_DONE: begin
                // Follow-up status read gives the caller the error bits.
                cyc.write = 1'b0;
                if (cycDone) begin
                    next_respData = cycRdata;
                    respValid = 1'b1;
                    next_state = ESLP_IDLE;
                end
            end
            default: next_state = ESLP_IDLE;
        endcase
        if (reqReady && statusOutputPin && !progSusp) begin
            next_progInSusp = 1'b0;
        end
        if (started && req.op == eslp_pkg::ESLP_OP_PROGRAM && eraseSusp
                && legal(req, eraseSusp, progSusp, progInSusp)) begin
            next_progInSusp = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ESLP_IDLE;
            cur <= '0;
            respData <= '0;
            eraseSusp <= 1'b0;
            progSusp <= 1'b0;
            progInSusp <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            respData <= next_respData;
            eraseSusp <= next_eraseSusp;
            progSusp <= next_progSusp;
            progInSusp <= next_progInSusp;
        end
    end

    assign nestLevel2 = progSusp;
    assign eraseSuspendedSeen = eraseSusp;

    // One bus cycle starts on entry to each cycle state and the final status read.
    logic cycStart;
    logic cycArmed, next_cycArmed;
    always_comb begin
        next_cycArmed = cycArmed;
        cycStart = 1'b0;
        if (state == ESLP_CYC1 || state == ESLP_CYC2 || state == ESLP_DONE) begin
            cycStart = !cycArmed && !cycBusy;
            if (cycStart) begin
                next_cycArmed = 1'b1;
            end
        end
        if (cycDone) begin
            next_cycArmed = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cycArmed <= 1'b0;
        end else begin
            cycArmed <= next_cycArmed;
        end
    end

    eslp_bus_cycle busCycle (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(cycStart),
        .cyc(cyc),
        .busy(cycBusy),
        .done(cycDone),
        .rdata(cycRdata),
        .flashAddr(flashAddr),
        .flashDqOut(flashDqOut),
        .flashDqOe_n(flashDqOe_n),
        .flashDqIn(flashDqIn),
        .flashCe_n(flashCe_n),
        .flashWe_n(flashWe_n),
        .flashOe_n(flashOe_n)
    );
endmodule

// ===== verification/eslp_host_ctrl_asserts.sv
`timescale 1ns/1ps
// Watches refusals, strobe shapes and bus turnaround at the host controller's ports.
module eslp_host_ctrl_asserts (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire eslp_pkg::eslp_req_s req,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic respValid,
    input wire logic refused,
    input wire logic nestLevel2,
    input wire logic [eslp_pkg::ADDR_W-1:0] flashAddr,
    input wire logic [eslp_pkg::DATA_W-1:0] flashDqOut,
    input wire logic flashDqOe_n,
    input wire logic flashCe_n,
    input wire logic flashWe_n,
    input wire logic flashOe_n,
    input wire logic statusOutputPin,
    input wire logic programEnableOk
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic take;
    logic isResume;
    logic isLock;
    // Request decode shared by the refusal checks.
    assign take = reqValid && reqReady;
    assign isResume = req.op == eslp_pkg::ESLP_OP_RESUME;
    assign isLock = req.op inside {eslp_pkg::ESLP_OP_SET_LOCK, eslp_pkg::ESLP_OP_CLEAR_LOCKS};
    resume_busy_ref_a: assert property (take && isResume && !statusOutputPin |-> refused)
        else $error("resume accepted while the device was busy");
    lock_guard_ref_a: assert property (take && isLock && !programEnableOk |-> refused)
        else $error("lock command accepted under supply lockout");
    refuse_answers_a: assert property (refused |-> respValid)
        else $error("refusal without a response");
    refuse_quiet_a: assert property (refused |-> flashCe_n ##1 flashCe_n)
        else $error("bus traffic after a refusal");
    write_width_a: assert property ($fell(flashWe_n) |-> (!flashWe_n && !flashCe_n)[*3] ##1 flashWe_n)
        else $error("write strobe of wrong width");
    write_drive_a: assert property (!flashWe_n |-> !flashDqOe_n && flashOe_n)
        else $error("data bus not driven during a write");
    read_release_a: assert property (!flashOe_n |-> flashDqOe_n && flashWe_n)
        else $error("data bus driven during a read");
    write_hold_a: assert property (!flashWe_n && $past(!flashWe_n) |-> $stable(flashDqOut) && $stable(flashAddr))
        else $error("address or data moved inside a write strobe");
    bus_not_ready_a: assert property (!flashCe_n |-> !reqReady)
        else $error("new request offered while a bus cycle runs");
    // Main scenarios that the bench is expected to reach.
    cover property (refused);
    cover property ($rose(nestLevel2));
    cover property (take && isLock && programEnableOk && statusOutputPin);
endmodule

bind eslp_host_ctrl eslp_host_ctrl_asserts chk (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .reqValid(reqValid), .reqReady(reqReady), .respValid(respValid), .refused(refused),
    .nestLevel2(nestLevel2), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqOe_n(flashDqOe_n), .flashCe_n(flashCe_n), .flashWe_n(flashWe_n),
    .flashOe_n(flashOe_n), .statusOutputPin(statusOutputPin), .programEnableOk(programEnableOk));

// ===== verification/eslp_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash device: decoder, status bits, lock bits and protection words.
module eslp_flash_model #(
    parameter int ERASE_CYC = 400,
    parameter int PROG_CYC = 60,
    parameter int SUSP_LAT = 5
) (
    input wire logic mclk,
    input wire logic programEnableOk,
    input wire logic [23:0] flashAddr,
    input wire logic [15:0] flashDqOut,
    input wire logic flashDqOe_n,
    output logic [15:0] flashDqIn,
    input wire logic flashCe_n,
    input wire logic flashWe_n,
    input wire logic flashOe_n,
    output logic statusOutputPin
);
    int erRem = 0, prRem = 0, suspWait = 0;
    logic eraseSusp = 1'b0, progSusp = 1'b0, prevWe = 1'b1, busy;
    logic [7:0] errs = 8'h00, pend = 8'h00, sr;
    logic [1:0] mode = 2'h0;
    logic [255:0] lockBits = '0;
    // Factory words are arbitrary; word 0 is the lock word with the user segment open.
    logic [15:0] prot [0:8] = '{16'hfffe, 16'h1111, 16'h2222, 16'h3333, 16'h4444,
        16'hffff, 16'hffff, 16'hffff, 16'hffff};
    logic [23:0] la = '0;
    logic [15:0] ld = '0, rdv, lastOut = '0;
    // Ready and the level pin; a released bus shows the inverse of its last value.
    always_comb begin
        busy = (prRem != 0 && !progSusp) || (erRem != 0 && !eraseSusp);
        sr = errs;
        sr[eslp_pkg::READY_BIT] = !busy;
        sr[eslp_pkg::ERASE_SUSPENDED_BIT] = eraseSusp;
        sr[2] = progSusp;
        statusOutputPin = !busy;
        rdv = (mode == 2'h0) ? {8'h00, sr} : (mode == 2'h1) ?
            prot[4'(flashAddr - eslp_pkg::PROT_BASE)] : 16'hffff;
        flashDqIn = !flashDqOe_n ? flashDqOut : (!flashCe_n && !flashOe_n) ? rdv : ~lastOut;
    end
    // Writes act on the rising strobe; operation timers run off the bus clock.
    always @(posedge mclk) begin
        prevWe <= flashWe_n;
        if (!flashCe_n && !flashOe_n) lastOut <= rdv;
        if (!flashCe_n && !flashWe_n) la <= flashAddr;
        if (!flashCe_n && !flashWe_n) ld <= flashDqOut;
        if (suspWait == 1 && prRem != 0) progSusp <= 1'b1;
        else if (suspWait == 1) eraseSusp <= 1'b1;
        if (suspWait != 0) suspWait <= suspWait - 1;
        if (prRem != 0 && !progSusp) prRem <= prRem - 1;
        else if (erRem != 0 && !eraseSusp && prRem == 0) erRem <= erRem - 1;
        if (flashWe_n && !prevWe) run_write();
    end
    task run_write();
        logic [7:0] c;
        logic [3:0] pi;
        c = ld[7:0];
        pi = 4'(la - eslp_pkg::PROT_BASE);
        mode <= 2'h0;
        pend <= 8'h00;
        if (pend == 8'h00) begin
            case (c)
                eslp_pkg::CMD_READ_ARRAY: mode <= 2'h2;
                eslp_pkg::CMD_READ_ID: mode <= 2'h1;
                eslp_pkg::CMD_CLEAR_STATUS: errs <= 8'h00;
                eslp_pkg::CMD_READ_STATUS: mode <= 2'h0;
                eslp_pkg::CMD_SUSPEND: if (busy) suspWait <= SUSP_LAT;
                eslp_pkg::CMD_CONFIRM: if (progSusp) progSusp <= 1'b0;
                    else if (prRem == 0) eraseSusp <= 1'b0;
                default: pend <= c;
            endcase
        end else if (pend != eslp_pkg::CMD_PROGRAM && (busy || eraseSusp || progSusp)) begin
            errs <= errs | 8'h30;
        end else if (pend == eslp_pkg::CMD_PROGRAM) begin
            if (lockBits[la[23:16]]) errs <= errs | 8'h12;
            else prRem <= PROG_CYC;
        end else if (pend == eslp_pkg::CMD_ERASE_SETUP && c == eslp_pkg::CMD_CONFIRM) begin
            erRem <= ERASE_CYC;
        end else if (pend == eslp_pkg::CMD_LOCK_SETUP && !programEnableOk) begin
            errs <= errs | (c == eslp_pkg::CMD_SET_LOCK ? 8'h18 : 8'h28);
        end else if (pend == eslp_pkg::CMD_LOCK_SETUP && c == eslp_pkg::CMD_SET_LOCK) begin
            lockBits[la[23:16]] <= 1'b1;
        end else if (pend == eslp_pkg::CMD_LOCK_SETUP && c == eslp_pkg::CMD_CONFIRM) begin
            lockBits <= '0;
        end else if (pend == eslp_pkg::CMD_PROT_SETUP) begin
            if (la < eslp_pkg::PROT_BASE || la > eslp_pkg::PROT_LAST) errs <= errs | 8'h10;
            else if (pi != 0 && la < eslp_pkg::PROT_USER_FIRST) errs <= errs | 8'h12;
            else if (!prot[0][1]) errs <= errs | 8'h12;
            else prot[pi] <= prot[pi] & ld;
        end else begin
            errs <= errs | 8'h30;
        end
    endtask
endmodule

// ===== verification/eslp_host_ctrl_test.sv
`timescale 1ns/1ps
module eslp_host_ctrl_test;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic reqValid = 1'b0;
    logic programEnableOk = 1'b0;
    eslp_pkg::eslp_req_s req = '0;
    logic reqReady, respValid, refused, nestLevel2, flashDqOe_n, flashCe_n, flashWe_n;
    logic flashOe_n, statusOutputPin, wasRef, esSeen;
    logic [15:0] respData, flashDqOut, flashDqIn, rsp;
    logic [23:0] flashAddr;
    int mismatches = 0;
    int cmp_count = 0;
    eslp_pkg::eslp_op_e badOps [5] = '{eslp_pkg::ESLP_OP_SET_LOCK, eslp_pkg::ESLP_OP_CLEAR_LOCKS,
        eslp_pkg::ESLP_OP_ERASE, eslp_pkg::ESLP_OP_PROT_PROGRAM, eslp_pkg::ESLP_OP_READ_ID};
    // A 40 ns period gives the 25 MHz bus clock.
    always #20 mclk = ~mclk;
    eslp_host_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .reqValid(reqValid),
        .reqReady(reqReady), .respValid(respValid), .respData(respData), .refused(refused),
        .nestLevel2(nestLevel2), .eraseSuspendedSeen(esSeen), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe_n(flashDqOe_n), .flashDqIn(flashDqIn),
        .flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n),
        .statusOutputPin(statusOutputPin), .programEnableOk(programEnableOk));
    eslp_flash_model dev (.mclk(mclk), .programEnableOk(programEnableOk), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe_n(flashDqOe_n), .flashDqIn(flashDqIn),
        .flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n),
        .statusOutputPin(statusOutputPin));
    task final_report();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Offers one request at a falling edge, holds it until taken, then waits for the answer.
    task automatic try(input eslp_pkg::eslp_op_e op, input logic [23:0] a,
        input logic [15:0] d, input logic expRef);
        int n;
        logic seen;
        n = 0;
        @(negedge mclk);
        req.op = op;
        req.addr = a;
        req.data = d;
        reqValid = 1'b1;
        #1;
        while (reqReady !== 1'b1 && n < 100) begin
            @(negedge mclk);
            #1;
            n++;
        end
        seen = (respValid === 1'b1);
        wasRef = seen && (refused === 1'b1);
        @(negedge mclk);
        reqValid = 1'b0;
        #1;
        while (!seen && respValid !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            #1;
            n++;
        end
        @(negedge mclk);
        rsp = respData;
        if (n >= 3000) mismatches++;
        chk_flag(wasRef, expRef);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (statusOutputPin !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        chk_flag(statusOutputPin, 1'b1);
    endtask
    // Hang guard, more than ten times the expected run.
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    // Lockout, locking, nested suspend and resume, then protection words.
    initial begin
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        try(eslp_pkg::ESLP_OP_SET_LOCK, 24'h010000, 16'h0000, 1'b1);
        try(eslp_pkg::ESLP_OP_CLEAR_LOCKS, 24'h000000, 16'h0000, 1'b1);
        programEnableOk = 1'b1;
        try(eslp_pkg::ESLP_OP_SET_LOCK, 24'h010000, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0080);
        chk_flag(dev.lockBits[1], 1'b1);
        try(eslp_pkg::ESLP_OP_PROGRAM, 24'h010004, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0092);
        try(eslp_pkg::ESLP_OP_CLEAR_STATUS, 24'h000000, 16'h0000, 1'b0);
        try(eslp_pkg::ESLP_OP_ERASE, 24'h040000, 16'h0000, 1'b0);
        try(eslp_pkg::ESLP_OP_SUSPEND, 24'h040000, 16'h0000, 1'b0);
        chk_word(rsp, 16'h00c0);
        chk_flag(esSeen, 1'b1);
        for (int i = 0; i < 5; i++) begin
            try(badOps[i], 24'h000085, 16'h0000, 1'b1);
        end
        try(eslp_pkg::ESLP_OP_PROGRAM, 24'h060000, 16'h1234, 1'b0);
        chk_word(rsp, 16'h0040);
        try(eslp_pkg::ESLP_OP_SUSPEND, 24'h060000, 16'h0000, 1'b0);
        chk_word(rsp, 16'h00c4);
        chk_flag(nestLevel2, 1'b1);
        try(eslp_pkg::ESLP_OP_RESUME, 24'habcdef, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0040);
        chk_flag(nestLevel2, 1'b0);
        try(eslp_pkg::ESLP_OP_RESUME, 24'h000000, 16'h0000, 1'b1);
        wait_ready();
        try(eslp_pkg::ESLP_OP_RESUME, 24'h123456, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0000);
        chk_flag(esSeen, 1'b0);
        wait_ready();
        try(eslp_pkg::ESLP_OP_SUSPEND, 24'h000000, 16'h0000, 1'b1);
        try(eslp_pkg::ESLP_OP_CLEAR_LOCKS, 24'h000000, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0080);
        chk_flag(dev.lockBits[1], 1'b0);
        try(eslp_pkg::ESLP_OP_PROT_PROGRAM, 24'h000090, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0090);
        try(eslp_pkg::ESLP_OP_CLEAR_STATUS, 24'h000000, 16'h0000, 1'b0);
        try(eslp_pkg::ESLP_OP_PROT_PROGRAM, 24'h000081, 16'h0000, 1'b0);
        chk_word(rsp, 16'h0092);
        try(eslp_pkg::ESLP_OP_CLEAR_STATUS, 24'h000000, 16'h0000, 1'b0);
        try(eslp_pkg::ESLP_OP_PROT_PROGRAM, 24'h000085, 16'h5a5a, 1'b0);
        chk_word(rsp, 16'h0080);
        try(eslp_pkg::ESLP_OP_READ_ID, 24'h000000, 16'h0000, 1'b0);
        try(eslp_pkg::ESLP_OP_READ, 24'h000085, 16'h0000, 1'b0);
        chk_word(rsp, 16'h5a5a);
        try(eslp_pkg::ESLP_OP_READ_ARRAY, 24'h000000, 16'h0000, 1'b0);
        try(eslp_pkg::ESLP_OP_READ, 24'h000100, 16'h0000, 1'b0);
        chk_word(rsp, 16'hffff);
        final_report();
    end
endmodule
